// file: eeprom_write_guard.sv
// Serial EEPROM write guard: status register, protection and pause
`timescale 1ns/10ps
module eeprom_write_guard
    import eeprom_guard_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DOC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic supply_ok,
    output logic so,
    output logic so_oe,
    output logic [7:0] status_word,
    output logic hardware_lock_mode,
    output logic software_lock_mode,
    output logic mem_write_start,
    output logic [ADDR_W-1:0] mem_write_addr,
    output logic [7:0] mem_write_data,
    output logic write_refused
);
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain, clocked by the serial clock
    logic frame_clr;
    logic pause_fall;
    logic pause_now;
    logic so_kill;
    logic so_drive;
    logic [2:0] bit_idx;
    logic [2:0] byte_cnt;
    logic [2:0] seen_bits;
    logic [2:0] seen_bytes;
    logic [7:0] shreg;
    logic [7:0] opcode;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data0;
    logic [7:0] status_snap;
    logic frame_tog;
    logic [7:0] next_byte;

    // The serial clock stops between frames, so frame state clears on deselect
    assign frame_clr = cs_n | ~rstn;
    // Clock high: pause keeps the level it had at the rise, so a change waits for the fall
    assign pause_now = sck ? pause_fall : ~hold_n; // RULE11 RULE12
    assign so_kill = frame_clr | pause_now; // RULE8
    // Gated here, not in the flop, so the line floats and returns the instant a pause does
    assign so_oe = so_drive & ~so_kill; // RULE8 RULE16
    assign next_byte = {shreg[6:0], si};

    always_ff @(posedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            pause_fall <= 1'b0;
        end else begin
            pause_fall <= ~hold_n; // RULE12
        end
    end

    always_ff @(posedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            bit_idx <= 3'h0;
            byte_cnt <= 3'h0;
        end else if (hold_n) begin // RULE8
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7 && byte_cnt != 3'h7) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
        end
    end

    // Frame contents survive deselect so the system side can judge them
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            shreg <= 8'h00;
            seen_bits <= 3'h0;
            seen_bytes <= 3'h0;
            frame_tog <= 1'b0;
        end else if (hold_n) begin // RULE8
            shreg <= next_byte;
            seen_bits <= bit_idx + 3'h1;
            if (bit_idx == 3'h7 && byte_cnt != 3'h7) begin
                seen_bytes <= byte_cnt + 3'h1;
            end else if (bit_idx == 3'h0 && byte_cnt == 3'h0) begin
                seen_bytes <= 3'h0;
            end
            if (bit_idx == 3'h0 && byte_cnt == 3'h0) begin
                frame_tog <= ~frame_tog;
            end
        end
    end

    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            opcode <= 8'h00;
            addr_hi <= 8'h00;
            addr_lo <= 8'h00;
            data0 <= 8'h00;
            status_snap <= 8'h00;
        end else if (hold_n && bit_idx == 3'h7) begin // RULE8
            // Status is quasi-static here; a snapshot taken mid-update may mix bits
            status_snap <= status_word;
            unique case (byte_cnt)
                3'h0: opcode <= next_byte;
                3'h1: addr_hi <= next_byte;
                3'h2: addr_lo <= next_byte;
                3'h3: data0 <= next_byte;
                default: data0 <= data0;
            endcase
        end
    end

    // Bit index is frozen while paused, so the same bit shows again when the pause ends
    always_ff @(negedge sck or posedge frame_clr) begin
        if (frame_clr) begin
            so <= 1'b0;
            so_drive <= 1'b0; // RULE16
        end else if (byte_cnt != 3'h0 && opcode == STATUS_READ_CMD) begin
            so <= status_snap[3'h7 - bit_idx];
            so_drive <= 1'b1; // RULE16
        end else begin
            so <= 1'b0;
            so_drive <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin and link synchronisation into the system clock
    logic [4:0] sync_q;
    logic supply_s;
    logic frame_tog_s;
    logic wp_s;
    logic hold_s;
    logic cs_s;
    logic cs_prev;
    logic frame_seen;
    logic cs_rise;

    pin_sync3 #(
        .W(5),
        .INIT(5'h17)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .d({supply_ok, frame_tog, wp_n, hold_n, cs_n}),
        .q(sync_q)
    );

    assign supply_s = sync_q[4];
    assign frame_tog_s = sync_q[3];
    assign wp_s = sync_q[2];
    assign hold_s = sync_q[1];
    assign cs_s = sync_q[0];
    assign cs_rise = cs_s & ~cs_prev;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_prev <= 1'b1;
            frame_seen <= 1'b0;
        end else begin
            cs_prev <= cs_s;
            if (cs_rise) begin
                frame_seen <= frame_tog_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command judgement at the end of each frame
    logic status_lock;
    logic [1:0] block_protect;
    logic write_enable_latch;
    logic write_in_progress;
    logic hw_lock;
    logic new_frame;
    logic whole_bytes;
    logic [ADDR_W-1:0] target;
    logic in_protected;
    logic status_allowed;
    logic memory_allowed;
    logic do_enable;
    logic do_disable;
    logic do_status;
    logic do_memory;
    logic refuse;

    assign hw_lock = status_lock & ~wp_s; // RULE4 RULE5
    // Only whole frames that ended while selected and unpaused count
    assign new_frame = cs_rise & (frame_tog_s != frame_seen) & hold_s; // RULE10 RULE15
    assign whole_bytes = seen_bits == 3'h0;
    assign target = {addr_hi[1:0], addr_lo}; // RULE19

    always_comb begin
        unique case (block_protect) // RULE6
            2'b00: in_protected = 1'b0;
            2'b01: in_protected = target >= QUARTER_BASE;
            2'b10: in_protected = target >= HALF_BASE;
            2'b11: in_protected = 1'b1;
        endcase
    end

    // Lock bit clear, or pin high, leaves only the latch and busy checks
    assign status_allowed = write_enable_latch & ~write_in_progress & ~hw_lock; // RULE1 RULE2 RULE3
    assign memory_allowed = write_enable_latch & ~write_in_progress & ~in_protected; // RULE7 RULE18

    assign do_enable = new_frame & whole_bytes & seen_bytes == CMD_BYTES
        & opcode == WRITE_ENABLE_CMD & ~write_in_progress;
    assign do_disable = new_frame & whole_bytes & seen_bytes == CMD_BYTES
        & opcode == WRITE_DISABLE_CMD & ~write_in_progress;
    assign do_status = new_frame & whole_bytes & seen_bytes == STATUS_WRITE_BYTES
        & opcode == STATUS_WRITE_CMD;
    assign do_memory = new_frame & whole_bytes & seen_bytes >= MEMORY_WRITE_BYTES
        & opcode == MEMORY_WRITE_CMD;
    assign refuse = (do_status & ~status_allowed) | (do_memory & ~memory_allowed); // RULE20

    ////////////////////////////////////////////////////////////////////////////
    // Internal write cycle
    write_state_e state;
    write_state_e next_state;
    logic [CNT_W-1:0] wait_cnt;
    logic status_pending;
    logic [7:0] status_new;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if ((do_status & status_allowed) | (do_memory & memory_allowed)) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (wait_cnt == CNT_LAST) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
        if (!supply_s) begin
            next_state = ST_IDLE; // RULE13
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= '0;
        end else if (state == ST_BUSY) begin
            wait_cnt <= wait_cnt + CNT_W'(1);
        end else begin
            wait_cnt <= '0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_pending <= 1'b0;
            status_new <= 8'h00;
        end else if (state == ST_IDLE) begin
            status_pending <= do_status & status_allowed;
            status_new <= addr_hi;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            write_in_progress <= 1'b0;
        end else begin
            write_in_progress <= next_state == ST_BUSY; // RULE20
        end
    end

    // Nonvolatile bits change only when a status write runs to completion
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_lock <= LOCK_RESET;
            block_protect <= PROT_RESET;
        end else if (state == ST_DONE && status_pending && supply_s) begin // RULE3 RULE13
            status_lock <= status_new[LOCK_POS];
            block_protect <= {status_new[PROT_HIGH_POS], status_new[PROT_LOW_POS]};
        end
    end

    // Power-on reset and supply drop both leave the latch cleared
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            write_enable_latch <= 1'b0; // RULE13
        end else if (!supply_s) begin
            write_enable_latch <= 1'b0; // RULE13
        end else if (do_enable) begin
            write_enable_latch <= 1'b1;
        end else if (do_disable || state == ST_DONE) begin
            write_enable_latch <= 1'b0; // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_write_start <= 1'b0;
            mem_write_addr <= '0;
            mem_write_data <= 8'h00;
            write_refused <= 1'b0;
        end else begin
            mem_write_start <= state == ST_IDLE & do_memory & memory_allowed & supply_s; // RULE18
            write_refused <= refuse; // RULE20
            if (state == ST_IDLE && do_memory && memory_allowed) begin
                mem_write_addr <= target; // RULE19
                mem_write_data <= data0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_word <= 8'h00;
            hardware_lock_mode <= 1'b0;
            software_lock_mode <= 1'b0;
        end else begin
            status_word <= 8'h00;
            status_word[LOCK_POS] <= status_lock; // RULE17
            status_word[PROT_HIGH_POS] <= block_protect[1];
            status_word[PROT_LOW_POS] <= block_protect[0];
            status_word[LATCH_POS] <= write_enable_latch;
            status_word[BUSY_POS] <= write_in_progress;
            hardware_lock_mode <= hw_lock; // RULE4 RULE5
            software_lock_mode <= ~hw_lock & (block_protect != 2'b00); // RULE5
        end
    end
endmodule // eeprom_write_guard

// file: eeprom_guard_pkg.sv
// Constants shared by the write guard, its port checker and its bench
//
// Summary of operation
// RULE1: Lock bit 0: status writes need latch only; the code also refuses them while busy
// RULE2: Lock bit 1, protect pin high: writes allowed
// RULE3: Lock bit 1, protect pin low: refuse
// RULE4: Lock entered in either order of bit/pin
// RULE5: Protect pin high releases hardware lock
// RULE6: Protect pair selects none, quarter, half, all
// RULE7: Latch clear blocks writes; protected range never
// RULE8: Paused: output floats, input and clock ignored
// RULE9: Host keeps select low while pausing
// RULE10: Deselect while paused ends the transfer
// RULE11: Pause edge with clock low acts at once
// RULE12: Pause edge with clock high waits falling edge
// RULE13: Supply drop aborts write, clears latch
// RULE14: Host re-enables writes after supply returns
// RULE15: Deselected device never starts a write
// RULE16: Serial output drives high, low or floats
// RULE17: Status bits: lock 7, protect 3:2, latch 1, busy 0
// RULE18: Memory write refused: latch clear, busy, protected
// RULE19: Only the low ten address bits count
// RULE20: Refused write changes nothing, busy stays 0
package eeprom_guard_pkg;
    localparam int ADDR_W = 10;
    localparam int LOCK_POS = 7;
    localparam int PROT_HIGH_POS = 3;
    localparam int PROT_LOW_POS = 2;
    localparam int LATCH_POS = 1;
    localparam int BUSY_POS = 0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic [1:0] PROT_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 10'h300;
    localparam logic [ADDR_W-1:0] HALF_BASE = 10'h200;
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] MEMORY_WRITE_CMD = 8'h02;
    localparam logic [2:0] CMD_BYTES = 3'h1;
    localparam logic [2:0] STATUS_WRITE_BYTES = 3'h2;
    localparam logic [2:0] MEMORY_WRITE_BYTES = 3'h4;
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int WRITE_TIME_NS = 4000000;
    localparam int WRITE_CYCLES_DOC = (WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } write_state_e;
endpackage

// file: pin_sync3.sv
// Three-stage synchroniser; a bit changes once stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= INIT;
        end else begin
            q <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
        end
    end
endmodule // pin_sync3

// file: serial_eeprom_write_guard_pause_assertions.sv
// Port checker for the write guard
`timescale 1ns/10ps
module guard_checker
    import eeprom_guard_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic supply_ok,
    input wire logic so_oe,
    input wire logic [7:0] status_word,
    input wire logic mem_write_start,
    input wire logic [ADDR_W-1:0] mem_write_addr,
    input wire logic write_refused
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    deselect_float_a: assert property (
        cs_n |-> !so_oe) else $error("output driven while deselected");
    pause_float_a: assert property (
        !hold_n && !sck |-> !so_oe) else $error("output driven while paused");
    quiet_deselect_a: assert property (
        cs_n [*8] |-> !mem_write_start && !write_refused) else $error("write while deselected");
    start_latch_a: assert property (
        mem_write_start |-> status_word[LATCH_POS] && !status_word[BUSY_POS])
        else $error("write started without latch or while busy");
    start_busy_a: assert property (
        mem_write_start |-> ##[1:3] status_word[BUSY_POS]) else $error("busy not raised");
    start_range_a: assert property (
        mem_write_start |-> status_word[3:2] == 2'h0
        || (status_word[3:2] == 2'h1 && mem_write_addr < 10'h300)
        || (status_word[3:2] == 2'h2 && mem_write_addr < 10'h200))
        else $error("write started in protected range");
    refuse_idle_a: assert property (
        write_refused && !status_word[BUSY_POS] |=> !status_word[BUSY_POS] [*4])
        else $error("refused write went busy");
    supply_drop_a: assert property (
        !supply_ok [*8] |-> status_word[1:0] == 2'h0) else $error("latch or busy kept in drop");
endmodule // guard_checker

bind eeprom_write_guard guard_checker chk_u (.clock(clock), .rstn(rstn), .sck(sck),
    .cs_n(cs_n), .hold_n(hold_n), .supply_ok(supply_ok), .so_oe(so_oe),
    .status_word(status_word), .mem_write_start(mem_write_start),
    .mem_write_addr(mem_write_addr), .write_refused(write_refused));

// file: spi_host.sv
// Serial host model: mode 0 frames with optional pause
`timescale 1ns/10ps
module spi_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    int pause_at = -1;
    bit pause_high = 0;
    bit end_paused = 0;
    logic [7:0] rd = 8'h00;
    logic [1:0] oe_seen = 2'h0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        hold_n = 1'b1;
    end
    ////////////////////////////////////////
    // Pulses while paused carry flipped data, so obeying them would corrupt the frame
    task automatic junk();
        repeat (2) begin
            si = ~si;
            #40 sck = 1'b1;
            #40 sck = 1'b0;
        end
    endtask
    task automatic frame(input logic [31:0] v, input int n);
        cs_n = 1'b0;
        #43;
        for (int i = 0; i < n; i++) begin
            si = v[n-1-i];
            #40;
            // Taken just before the rise; a released line reads inverted so it cannot pass
            rd = {rd[6:0], so_oe ? so : ~so};
            sck = 1'b1;
            if (i == pause_at && pause_high) begin
                #10 hold_n = 1'b0;
                #10 oe_seen[0] = so_oe;
                #20 sck = 1'b0;
                #20 oe_seen[1] = so_oe;
                cs_n = 1'b1;
                #80 hold_n = 1'b1;
                return;
            end
            #40 sck = 1'b0;
            if (i == pause_at) begin
                #10 hold_n = 1'b0;
                #10 oe_seen[0] = so_oe;
                junk();
                if (end_paused) begin
                    cs_n = 1'b1;
                    #80 hold_n = 1'b1;
                    return;
                end
                #10 hold_n = 1'b1;
            end
        end
        #40 cs_n = 1'b1;
        si = 1'b1;
    endtask
endmodule // spi_host

// file: serial_eeprom_write_guard_pause_tb.sv
// Self-checking bench of the write guard
`timescale 1ns/10ps
module serial_eeprom_write_guard_pause_tb;
    import eeprom_guard_pkg::*;
    localparam int WC = 300;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1;
    logic supply_ok = 1'b1;
    logic sck, cs_n, si, hold_n, so, so_oe, hw, sw, start, refused;
    logic [7:0] status, wdata;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] probe [4] = '{10'h1FF, 10'h200, 10'h2FF, 10'h300};
    int bad_count = 0;
    int cmp_count = 0;
    int starts = 0;
    int refusals = 0;
    always #10 clock = ~clock;
    always @(posedge clock) begin
        starts <= starts + int'(start === 1'b1);
        refusals <= refusals + int'(refused === 1'b1);
    end
    spi_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
    eeprom_write_guard #(.WRITE_CYCLES(WC)) dut_u (.clock(clock), .rstn(rstn), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .supply_ok(supply_ok), .so(so),
        .so_oe(so_oe), .status_word(status), .hardware_lock_mode(hw), .software_lock_mode(sw),
        .mem_write_start(start), .mem_write_addr(waddr), .mem_write_data(wdata),
        .write_refused(refused));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic cmd(input logic [31:0] v, input int n);
        host_u.frame(v, n);
        tick(14);
    endtask
    task automatic wr_status(input logic [7:0] d);
        cmd(32'(WRITE_ENABLE_CMD), 8);
        cmd({16'h0, STATUS_WRITE_CMD, d}, 16);
        tick(WC + 20);
    endtask
    function automatic logic prot(input int b, input logic [ADDR_W-1:0] a);
        return b == 3 || (b == 2 && a >= 10'h200) || (b == 1 && a >= 10'h300);
    endfunction
    task automatic mem_write(input logic [ADDR_W-1:0] a, input logic ok);
        int s0;
        int r0;
        cmd(32'(WRITE_ENABLE_CMD), 8);
        s0 = starts;
        r0 = refusals;
        cmd({MEMORY_WRITE_CMD, 6'h3F, a, a[7:0] ^ 8'h5A}, 32);
        check("start", 16'(ok), 16'(starts - s0));
        check("refusal", 16'(!ok), 16'(refusals - r0));
        if (ok) begin
            check("addr", 16'(a), 16'(waddr));
            check("data", 16'(a[7:0] ^ 8'h5A), 16'(wdata));
            tick(WC + 20);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #1500000;
        bad_count++;
        conclude();
    end
    initial begin
        int r;
        tick(6);
        rstn = 1'b1;
        tick(10);
        check("status", 8'h00, status);
        cmd({16'h0, STATUS_READ_CMD, 8'h00}, 16);
        check("read", 8'h00, host_u.rd);
        cmd(32'(WRITE_ENABLE_CMD), 8);
        check("status", 8'h02, status);
        cmd(32'(WRITE_DISABLE_CMD), 8);
        check("status", 8'h00, status);
        r = refusals;
        cmd({16'h0, STATUS_WRITE_CMD, 8'h8C}, 16);
        check("refusal", 1, 16'(refusals - r));
        check("status", 8'h00, status);
        $display("test latch done");
        for (int b = 0; b < 4; b++) begin
            wr_status(8'(b << 2));
            check("status", 16'(b << 2), status);
            check("soft lock", 16'(b != 0), sw);
            foreach (probe[k]) mem_write(probe[k], !prot(b, probe[k]));
        end
        wr_status(8'h00);
        $display("test ranges done");
        wp_n = 1'b0;
        wr_status(8'h80);
        check("status", 8'h80, status);
        check("hard lock", 1, hw);
        wp_n = 1'b1;
        wr_status(8'h84);
        check("status", 8'h84, status);
        check("hard lock", 0, hw);
        check("soft lock", 1, sw);
        wp_n = 1'b0;
        tick(8);
        check("hard lock", 1, hw);
        r = refusals;
        wr_status(8'h00);
        check("refusal", 1, 16'(refusals - r));
        check("status", 8'h86, status);
        wp_n = 1'b1;
        wr_status(8'h00);
        check("status", 8'h00, status);
        $display("test lock done");
        cmd(32'(WRITE_ENABLE_CMD), 8);
        cmd({MEMORY_WRITE_CMD, 16'h0010, 8'hA5}, 32);
        check("status", 8'h03, status);
        r = refusals;
        cmd({MEMORY_WRITE_CMD, 16'h0011, 8'hA5}, 32);
        check("refusal", 1, 16'(refusals - r));
        tick(WC);
        check("status", 8'h00, status);
        $display("test busy done");
        cmd(32'(WRITE_ENABLE_CMD), 8);
        cmd({16'h0, STATUS_WRITE_CMD, 8'h8C}, 16);
        supply_ok = 1'b0;
        tick(12);
        check("status", 8'h00, status);
        supply_ok = 1'b1;
        tick(WC);
        check("status", 8'h00, status);
        r = refusals;
        cmd({MEMORY_WRITE_CMD, 24'h0}, 32);
        check("refusal", 1, 16'(refusals - r));
        cmd(32'(WRITE_ENABLE_CMD), 8);
        $display("test supply done");
        host_u.pause_at = 10;
        cmd({16'h0, STATUS_READ_CMD, 8'h00}, 16);
        check("read", 8'h02, host_u.rd);
        check("paused drive", 0, host_u.oe_seen[0]);
        host_u.pause_high = 1'b1;
        cmd({16'h0, STATUS_READ_CMD, 8'h00}, 16);
        check("drive before fall", 1, host_u.oe_seen[0]);
        check("drive after fall", 0, host_u.oe_seen[1]);
        host_u.pause_high = 1'b0;
        host_u.end_paused = 1'b1;
        host_u.pause_at = 7;
        cmd(32'(WRITE_DISABLE_CMD), 8);
        check("status", 8'h02, status);
        host_u.pause_at = -1;
        $display("test pause done");
        conclude();
    end
endmodule // serial_eeprom_write_guard_pause_tb
